// ### verilog/xor_chain_board_test.sv
// Board-test parity chains with Avalon-MM control and status
// Function
// - Straps low, power-good rises, then reset releases
// - Test mode parity works with no clock
// - No evaluation before reset-in is released
// - All chains may be exercised together
// - Each chain outputs parity of its pins
// - Twelve chains, output table lists twelve
// - Outputs map to mask and host pins
// - Full width: both channel pins equal
// - Shared mode: only exercised channel shows result
// - Chain 0 has sixty inputs
// - Chain 1 has thirty-three inputs
// - Chain 2 has forty-four inputs
`timescale 1ns/1ps
`default_nettype none

module xor_chain_board_test #(
	parameter int OTHER_W = xor_chain_pkg::CHAIN_OTHER_W
) (
	// Clock and reset
	input  wire logic                                 clk_in,
	input  wire logic                                 rst_in,
	// Avalon-MM slave
	input  wire logic [7:0]                           avs_address_in,
	input  wire logic                                 avs_read_in,
	input  wire logic                                 avs_write_in,
	input  wire logic [31:0]                          avs_writedata_in,
	input  wire logic [3:0]                           avs_byteenable_in,
	output logic [31:0]                               avs_readdata_out,
	output logic                                      avs_waitrequest_out,
	// Entry straps and control pins
	input  wire logic                                 addr_id_strap_6_in,
	input  wire logic                                 addr_id_strap_7_in,
	input  wire logic                                 test_entry_strap_n_in,
	input  wire logic                                 power_good_in,
	input  wire logic                                 reset_in_n_in,
	input  wire logic                                 video_b_blank_n_in,
	// Named chain members
	input  wire logic                                 ext_thermal_sense_n_in,
	input  wire logic                                 proc_overtemp_n_in,
	input  wire logic                                 hit_modified_n_in,
	input  wire logic                                 bus_speed_sel_0_in,
	input  wire logic                                 host_lock_n_in,
	// Remaining chain members
	input  wire logic [xor_chain_pkg::CHAIN0_BUS_W-1:0] chain0_pins_in,
	input  wire logic [xor_chain_pkg::CHAIN1_BUS_W-1:0] chain1_pins_in,
	input  wire logic [xor_chain_pkg::CHAIN2_BUS_W-1:0] chain2_pins_in,
	input  wire logic [9*OTHER_W-1:0]                 chain_hi_pins_in,
	// Monitor outputs
	output logic [7:0]                                chan_a_mask_out,
	output logic [7:0]                                chan_b_mask_out,
	output logic                                      host_target_rdy_n_out,
	output logic                                      priority_bus_req_n_out,
	output logic                                      host_response_2_n_out,
	output logic                                      host_n_a_out,
	output logic                                      host_response_0_n_out,
	output logic                                      host_response_1_n_out,
	output logic                                      bus_request_0_n_out,
	output logic                                      processor_reset_n_out,
	output logic                                      monitor_oe_out
);

	localparam int N = xor_chain_pkg::NUM_OUTPUTS;

	// ============================================================
	// Decode helpers
	function automatic logic pair_conflict(input logic [N-1:0] en);
		pair_conflict = (en[0] & en[1]) | (en[0] & en[2]) | (en[2] & en[4]);
	endfunction : pair_conflict

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	// ============================================================
	// Clockless parity trees
	logic [xor_chain_pkg::CHAIN0_WIDTH-1:0] chain0_vec;
	logic [xor_chain_pkg::CHAIN1_WIDTH-1:0] chain1_vec;
	logic [xor_chain_pkg::CHAIN2_WIDTH-1:0] chain2_vec;
	logic [N-1:0]                           parity;
	logic [N-1:0]                           result;
	logic [N-1:0]                           side_a;
	logic [N-1:0]                           side_b;
	logic                                   eval_active;
	logic [1:0]                             chan_mode_ff;
	logic [N-1:0]                           chain_en_ff;

	assign chain0_vec = {addr_id_strap_7_in, addr_id_strap_6_in, video_b_blank_n_in, chain0_pins_in};
	assign chain1_vec = {ext_thermal_sense_n_in, chain1_pins_in};
	assign chain2_vec = {host_lock_n_in, bus_speed_sel_0_in, hit_modified_n_in, proc_overtemp_n_in,
		chain2_pins_in};

	// Evaluation gated by pin levels alone so no clock is needed
	assign eval_active = ~test_entry_strap_n_in & power_good_in & reset_in_n_in;

	assign parity[0] = ^chain0_vec;
	assign parity[1] = ^chain1_vec;
	assign parity[2] = ^chain2_vec;

	genvar gi;
	generate
		for (gi = 3; gi < N; gi++) begin : g_hi_chain
			assign parity[gi] = ^chain_hi_pins_in[(gi-3)*OTHER_W +: OTHER_W];
		end
	endgenerate

	// All chains evaluate in parallel; enables let the tester separate pairs
	assign result = eval_active ? (parity & chain_en_ff) : '0;

	assign side_a = (chan_mode_ff == xor_chain_pkg::MODE_CHAN_B) ? '0 : result;
	assign side_b = (chan_mode_ff == xor_chain_pkg::MODE_CHAN_A) ? '0 : result;

	// ============================================================
	// Output pin mapping
	assign chan_a_mask_out        = side_a[7:0];
	assign chan_b_mask_out        = side_b[7:0];
	assign host_target_rdy_n_out  = side_a[8];
	assign priority_bus_req_n_out = side_b[8];
	assign host_response_2_n_out  = side_a[9];
	assign host_n_a_out           = side_b[9];
	assign host_response_0_n_out  = side_a[10];
	assign host_response_1_n_out  = side_b[10];
	assign bus_request_0_n_out    = side_a[11];
	assign processor_reset_n_out  = side_b[11];
	assign monitor_oe_out         = ~test_entry_strap_n_in & power_good_in;

	// ============================================================
	// Pin synchronisers
	localparam int SW = $bits(xor_chain_pkg::strap_pins_t) + N;
	logic [SW-1:0]                sync1_ff;
	logic [SW-1:0]                sync2_ff;
	logic [SW-1:0]                sync3_ff;
	logic [SW-1:0]                filt_ff;
	logic [SW-1:0]                raw_pins;
	xor_chain_pkg::strap_pins_t   pins_s;
	logic [N-1:0]                 result_s;

	assign raw_pins = {result, addr_id_strap_7_in, addr_id_strap_6_in, test_entry_strap_n_in,
		reset_in_n_in, power_good_in};

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else begin
			sync1_ff <= raw_pins;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// A level counts once the second and third stages agree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			filt_ff <= '0;
		end else begin
			for (int i = 0; i < SW; i++) begin
				if (sync2_ff[i] == sync3_ff[i]) begin
					filt_ff[i] <= sync3_ff[i];
				end
			end
		end
	end

	assign pins_s   = xor_chain_pkg::strap_pins_t'(filt_ff[4:0]);
	assign result_s = filt_ff[SW-1:5];

	// ============================================================
	// Entry sequence tracker
	xor_chain_pkg::entry_state_t state_ff;
	xor_chain_pkg::entry_state_t nxt_state;
	logic                        all_low;

	assign all_low = ~pins_s.id6 & ~pins_s.id7 & ~pins_s.strap_n & ~pins_s.pwr_good & ~pins_s.rst_n;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			xor_chain_pkg::ST_OFF: begin
				if (all_low) begin
					nxt_state = xor_chain_pkg::ST_ARMED;
				end
			end
			xor_chain_pkg::ST_ARMED: begin
				if (pins_s.pwr_good && !pins_s.rst_n) begin
					nxt_state = pins_s.strap_n ? xor_chain_pkg::ST_OFF : xor_chain_pkg::ST_POWERED;
				end else if (!all_low) begin
					nxt_state = xor_chain_pkg::ST_OFF;
				end
			end
			xor_chain_pkg::ST_POWERED: begin
				if (!pins_s.pwr_good) begin
					nxt_state = xor_chain_pkg::ST_OFF;
				end else if (pins_s.rst_n) begin
					nxt_state = xor_chain_pkg::ST_TEST;
				end
			end
			xor_chain_pkg::ST_TEST: begin
				if (!pins_s.rst_n && pins_s.strap_n) begin
					nxt_state = xor_chain_pkg::ST_NORMAL;
				end
			end
			xor_chain_pkg::ST_NORMAL: begin
				if (all_low) begin
					nxt_state = xor_chain_pkg::ST_ARMED;
				end
			end
			default: begin
				nxt_state = xor_chain_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= xor_chain_pkg::ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ============================================================
	// Avalon-MM slave: one wait state, then the answer
	logic                    ack_ff;
	logic                    req;
	logic                    wr_go;
	logic [31:0]             nxt_rdata;
	xor_chain_pkg::status_t  status;

	assign req                 = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~ack_ff;
	assign wr_go               = avs_write_in & ack_ff;

	assign status.test_mode     = ~pins_s.strap_n & pins_s.pwr_good;
	assign status.eval_active   = status.test_mode & pins_s.rst_n;
	assign status.pair_conflict = pair_conflict(chain_en_ff);
	assign status.seq_test      = (state_ff == xor_chain_pkg::ST_TEST);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req & ~ack_ff;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			chan_mode_ff <= xor_chain_pkg::RST_CHAN_MODE;
		end else if (wr_go && avs_byteenable_in[0] && reg_hit(avs_address_in, xor_chain_pkg::OFS_CTRL)) begin
			chan_mode_ff <= avs_writedata_in[xor_chain_pkg::CTRL_MODE_LSB +: 2];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			chain_en_ff <= xor_chain_pkg::RST_CHAIN_EN;
		end else if (wr_go && reg_hit(avs_address_in, xor_chain_pkg::OFS_CHAIN_EN)) begin
			if (avs_byteenable_in[0]) begin
				chain_en_ff[7:0] <= avs_writedata_in[7:0];
			end
			if (avs_byteenable_in[1]) begin
				chain_en_ff[N-1:8] <= avs_writedata_in[N-1:8];
			end
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (reg_hit(avs_address_in, xor_chain_pkg::OFS_CTRL)) begin
			nxt_rdata[1:0] = chan_mode_ff;
		end else if (reg_hit(avs_address_in, xor_chain_pkg::OFS_CHAIN_EN)) begin
			nxt_rdata[N-1:0] = chain_en_ff;
		end else if (reg_hit(avs_address_in, xor_chain_pkg::OFS_STATUS)) begin
			nxt_rdata[3:0] = status;
		end else if (reg_hit(avs_address_in, xor_chain_pkg::OFS_RESULT)) begin
			nxt_rdata[N-1:0] = result_s;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && !ack_ff) begin
			avs_readdata_out <= nxt_rdata;
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_powered_up;
		state_ff == xor_chain_pkg::ST_POWERED && !pins_s.rst_n;
	endsequence

	sequence s_reset_release;
		pins_s.rst_n && pins_s.pwr_good;
	endsequence

	a_entry_sequence: assert property (s_powered_up ##1 s_reset_release |=> state_ff == xor_chain_pkg::ST_TEST)
		else $error("entry sequence did not reach test state");
	a_exit_on_strap: assert property (state_ff == xor_chain_pkg::ST_TEST && !pins_s.rst_n && pins_s.strap_n
		|=> state_ff == xor_chain_pkg::ST_NORMAL)
		else $error("test state not left on reset with strap high");
	a_no_eval_reset: assert property (!reset_in_n_in |-> result == '0)
		else $error("chain result visible while reset-in asserted");
	a_full_width_eq: assert property (chan_mode_ff == xor_chain_pkg::MODE_FULL
		|-> chan_a_mask_out == chan_b_mask_out && host_target_rdy_n_out == priority_bus_req_n_out)
		else $error("channel pins differ in full width mode");
	a_chan_a_only: assert property (chan_mode_ff == xor_chain_pkg::MODE_CHAN_A
		|-> chan_b_mask_out == 8'h00 && chan_a_mask_out == result[7:0])
		else $error("channel B shows result in channel A mode");
	a_chain0_parity: assert property (eval_active && chain_en_ff[0] && chan_mode_ff != xor_chain_pkg::MODE_CHAN_B
		|-> chan_a_mask_out[0] == ^{chain0_pins_in, video_b_blank_n_in, addr_id_strap_6_in,
		addr_id_strap_7_in})
		else $error("chain 0 parity wrong");
	a_chain1_parity: assert property (eval_active && chain_en_ff[1] && chan_mode_ff != xor_chain_pkg::MODE_CHAN_A
		|-> chan_b_mask_out[1] == ^{chain1_pins_in, ext_thermal_sense_n_in})
		else $error("chain 1 parity wrong");
	a_chain2_host: assert property (eval_active && chain_en_ff[2]
		|-> result[2] == ^{chain2_pins_in, proc_overtemp_n_in, hit_modified_n_in, bus_speed_sel_0_in,
		host_lock_n_in})
		else $error("chain 2 parity wrong");
	a_pair_flag: assert property (chain_en_ff[0] && chain_en_ff[2] |-> status.pair_conflict)
		else $error("conflicting chain pair not flagged");
	a_host_pin_map: assert property (chan_mode_ff == xor_chain_pkg::MODE_CHAN_B
		|-> processor_reset_n_out == result[11] && bus_request_0_n_out == 1'b0)
		else $error("host pin pair mapping wrong");
	a_bus_answer: assert property (req && !ack_ff |=> !avs_waitrequest_out)
		else $error("bus answer not given after one wait state");

endmodule : xor_chain_board_test

`default_nettype wire

// ### verilog/xor_chain_pkg.sv
// Constants, register map and types for the board-test parity chains
package xor_chain_pkg;

	// ============================================================
	// Chain geometry
	localparam int NUM_OUTPUTS      = 12;
	localparam int CHAIN0_WIDTH     = 60;
	localparam int CHAIN1_WIDTH     = 33;
	localparam int CHAIN2_WIDTH     = 44;
	localparam int CHAIN_OTHER_W    = 40;
	// Chain 0 pins apart from the two straps and the blank input
	localparam int CHAIN0_BUS_W     = 57;
	// Chain 1 pins apart from the thermal sense input
	localparam int CHAIN1_BUS_W     = 32;
	// Chain 2 pins apart from overtemp, hit, speed select and lock
	localparam int CHAIN2_BUS_W     = 40;

	// ============================================================
	// Register map (byte offsets)
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_CHAIN_EN = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_RESULT   = 8'h0C;

	// Field positions and reset values
	localparam int          CTRL_MODE_LSB   = 0;
	localparam int          STAT_TEST_BIT   = 0;
	localparam int          STAT_EVAL_BIT   = 1;
	localparam int          STAT_CONF_BIT   = 2;
	localparam int          STAT_SEQ_BIT    = 3;
	localparam logic [1:0]  RST_CHAN_MODE   = 2'h0;
	localparam logic [11:0] RST_CHAIN_EN    = 12'hFFF;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;

	// ============================================================
	// Types
	typedef enum logic [1:0] {
		MODE_FULL,
		MODE_CHAN_A,
		MODE_CHAN_B,
		MODE_RSVD
	} chan_mode_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ARMED,
		ST_POWERED,
		ST_TEST,
		ST_NORMAL
	} entry_state_t;

	typedef struct packed {
		logic seq_test;
		logic pair_conflict;
		logic eval_active;
		logic test_mode;
	} status_t;

	typedef struct packed {
		logic id7;
		logic id6;
		logic strap_n;
		logic rst_n;
		logic pwr_good;
	} strap_pins_t;

endpackage : xor_chain_pkg

// ### test/pin_tester_model.sv
// Board tester model driving the entry straps and control pins
`timescale 1ns/1ps
`default_nettype none

module pin_tester_model (
	// Clock and commands
	input  wire logic clk_in,
	input  wire logic enter_in,
	input  wire logic exit_in,
	input  wire logic agp3_in,
	// Driven pins
	output logic      strap_6_out,
	output logic      strap_7_out,
	output logic      strap_n_out,
	output logic      power_good_out,
	output logic      reset_n_out,
	output logic      blank_n_out,
	output logic      host_clk_pos_out,
	output logic      host_clk_neg_out
);
	logic [2:0] step_ff;
	logic [1:0] dwell_ff;

	initial begin
		step_ff = 3'h0;
		dwell_ff = 2'h0;
		{strap_6_out, strap_7_out, power_good_out, reset_n_out} = 4'h0;
		{strap_n_out, blank_n_out, host_clk_pos_out} = 3'h6;
	end

	// ============================================================
	// Entry sequence
	always @(posedge clk_in) begin
		// Entry steps 1 to 3 each dwell four cycles so the synchronised tracker sees them; step 4 holds
		dwell_ff <= enter_in ? 2'h0 : dwell_ff + 2'h1;
		if (enter_in)
			step_ff <= 3'h1;
		else if (step_ff != 3'h0 && step_ff != 3'h4 && dwell_ff == 2'h3)
			step_ff <= step_ff + 3'h1;
		case (step_ff)
			3'h1: {strap_6_out, strap_7_out, strap_n_out, power_good_out, reset_n_out} <= 5'h00;
			3'h2: power_good_out <= 1'b1;
			3'h3: reset_n_out <= 1'b1;
			3'h4: if (agp3_in) {strap_6_out, strap_7_out, blank_n_out} <= 3'h7;
			default: ;
		endcase
		if (step_ff == 3'h4)
			host_clk_pos_out <= ~host_clk_pos_out;
		if (exit_in) begin
			strap_n_out <= 1'b1;
			reset_n_out <= 1'b0;
		end
	end

	assign host_clk_neg_out = ~host_clk_pos_out;
endmodule : pin_tester_model

`default_nettype wire

// ### test/xor_chain_board_test_tb_top.sv
// Self-checking bench for the board-test parity chains
`timescale 1ns/1ps
`default_nettype none

module xor_chain_board_test_tb_top;
	localparam int OW = 8;
	logic clk_in, rst_in, avs_read, avs_write, avs_wait, enter, leave, agp3;
	logic [7:0]  avs_addr;
	logic [31:0] avs_wdata, avs_rdata, q;
	logic [3:0]  avs_be;
	logic [56:0] c0;
	logic [31:0] c1;
	logic [39:0] c2;
	logic [9*OW-1:0] hi;
	logic ext, hot, hit_modified_n, bsel, lock;
	logic s6, s7, sn, pg, rn, bl, oe;
	logic [7:0] am, bm;
	logic [3:0] oa, ob;
	logic [1:0] mode;
	logic [11:0] en;
	int fails, comparisons, cycles;

	// ============================================================
	// Instances
	xor_chain_board_test #(.OTHER_W(OW)) uut (.clk_in(clk_in), .rst_in(rst_in),
		.avs_address_in(avs_addr), .avs_read_in(avs_read), .avs_write_in(avs_write),
		.avs_writedata_in(avs_wdata), .avs_byteenable_in(avs_be), .avs_readdata_out(avs_rdata),
		.avs_waitrequest_out(avs_wait), .addr_id_strap_6_in(s6), .addr_id_strap_7_in(s7),
		.test_entry_strap_n_in(sn), .power_good_in(pg), .reset_in_n_in(rn), .video_b_blank_n_in(bl),
		.ext_thermal_sense_n_in(ext), .proc_overtemp_n_in(hot), .hit_modified_n_in(hit_modified_n),
		.bus_speed_sel_0_in(bsel), .host_lock_n_in(lock), .chain0_pins_in(c0), .chain1_pins_in(c1),
		.chain2_pins_in(c2), .chain_hi_pins_in(hi), .chan_a_mask_out(am), .chan_b_mask_out(bm),
		.host_target_rdy_n_out(oa[0]), .priority_bus_req_n_out(ob[0]), .host_response_2_n_out(oa[1]),
		.host_n_a_out(ob[1]), .host_response_0_n_out(oa[2]), .host_response_1_n_out(ob[2]),
		.bus_request_0_n_out(oa[3]), .processor_reset_n_out(ob[3]), .monitor_oe_out(oe));

	pin_tester_model tester (.clk_in(clk_in), .enter_in(enter), .exit_in(leave), .agp3_in(agp3),
		.strap_6_out(s6), .strap_7_out(s7), .strap_n_out(sn), .power_good_out(pg), .reset_n_out(rn),
		.blank_n_out(bl), .host_clk_pos_out(), .host_clk_neg_out());

	// ============================================================
	// Clock, reset and timeout
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			finish_test();
		end
	end

	// ============================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		logic ws;
		@(posedge clk_in);
		avs_read <= !w;
		avs_write <= w;
		avs_addr <= a;
		avs_wdata <= d;
		avs_be <= b;
		do begin
			@(posedge clk_in);
			ws = avs_wait;
			q = avs_rdata;
		end while (ws !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	function automatic logic [11:0] parity();
		logic [11:0] p;
		p[0] = ^{c0, bl, s6, s7};
		p[1] = ^{c1, ext};
		p[2] = ^{c2, hot, hit_modified_n, bsel, lock};
		for (int k = 3; k < 12; k++)
			p[k] = ^hi[(k-3)*OW +: OW];
		return p;
	endfunction : parity

	task automatic chk_pins();
		logic [11:0] r;
		#1;
		r = parity() & en & {12{!sn && pg && rn}};
		check(32'({oa, am}), 32'((mode == 2'h2) ? 12'h000 : r), "side a pins");
		check(32'({ob, bm}), 32'((mode == 2'h1) ? 12'h000 : r), "side b pins");
	endtask : chk_pins

	task automatic set_reg(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
		if (a == xor_chain_pkg::OFS_CTRL)
			mode = d[1:0];
		if (a == xor_chain_pkg::OFS_CHAIN_EN)
			en = d[11:0];
	endtask : set_reg

	// ============================================================
	// Scenarios
	task automatic t_regs();
		bus(1'b0, xor_chain_pkg::OFS_CTRL, 32'h0, 4'hF);
		check(q, 32'h0000_0000, "ctrl reset");
		bus(1'b0, xor_chain_pkg::OFS_CHAIN_EN, 32'h0, 4'hF);
		check(q, 32'h0000_0FFF, "enable reset");
		bus(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
		bus(1'b0, 8'h10, 32'h0, 4'hF);
		check(q, 32'h0000_0000, "unmapped read");
		bus(1'b1, xor_chain_pkg::OFS_CHAIN_EN, 32'h0000_0000, 4'h1);
		bus(1'b0, xor_chain_pkg::OFS_CHAIN_EN, 32'h0, 4'hF);
		check(q, 32'h0000_0F00, "lane 0 write");
		set_reg(xor_chain_pkg::OFS_CHAIN_EN, 32'h0000_0FFF);
	endtask : t_regs

	task automatic t_entry();
		@(posedge clk_in);
		enter <= 1'b1;
		@(posedge clk_in);
		enter <= 1'b0;
		while (!(pg === 1'b1 && rn === 1'b0)) begin
			@(posedge clk_in);
			#1;
		end
		check(32'({oa, am, ob, bm}), 32'h0, "held in reset");
		chk_pins();
		while (rn !== 1'b1)
			@(posedge clk_in);
		chk_pins();
		check(32'(oe), 32'h1, "monitor enable");
	endtask : t_entry

	task automatic t_walk();
		for (int i = 0; i < 57; i++) begin
			@(posedge clk_in);
			c0[i] <= ~c0[i];
			chk_pins();
		end
		for (int i = 0; i < 32; i++) begin
			@(posedge clk_in);
			c1[i] <= ~c1[i];
			chk_pins();
		end
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_in);
			c2[i] <= ~c2[i];
			chk_pins();
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_in);
			{ext, hot, hit_modified_n, bsel, lock} <= {ext, hot, hit_modified_n, bsel, lock} ^ (5'h01 << i);
			chk_pins();
		end
		for (int k = 0; k < 9; k++) begin
			@(posedge clk_in);
			hi[k*OW] <= ~hi[k*OW];
			chk_pins();
		end
	endtask : t_walk

	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			set_reg(xor_chain_pkg::OFS_CTRL, 32'(m));
			chk_pins();
		end
	endtask : t_modes

	task automatic t_enable();
		logic [11:0] sets [5] = '{12'h003, 12'h005, 12'h014, 12'h00A, 12'hFF8};
		for (int s = 0; s < 5; s++) begin
			set_reg(xor_chain_pkg::OFS_CHAIN_EN, 32'(sets[s]));
			chk_pins();
			repeat (6) @(posedge clk_in);
			bus(1'b0, xor_chain_pkg::OFS_STATUS, 32'h0, 4'hF);
			check(q, 32'((s < 3) ? 4'hF : 4'hB), "status");
			bus(1'b0, xor_chain_pkg::OFS_RESULT, 32'h0, 4'hF);
			check(q, 32'(parity() & en), "result reg");
		end
	endtask : t_enable

	task automatic t_agp3();
		@(posedge clk_in);
		agp3 <= 1'b1;
		repeat (2) @(posedge clk_in);
		check(32'({s6, s7, bl}), 32'h7, "straps high");
		chk_pins();
	endtask : t_agp3

	task automatic t_exit();
		@(posedge clk_in);
		leave <= 1'b1;
		@(posedge clk_in);
		leave <= 1'b0;
		chk_pins();
		check(32'(oe), 32'h0, "monitor off");
		repeat (6) @(posedge clk_in);
		bus(1'b0, xor_chain_pkg::OFS_STATUS, 32'h0, 4'hF);
		check(q, 32'h0000_0000, "status off");
	endtask : t_exit

	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	// ============================================================
	// Main sequence
	initial begin
		{fails, comparisons, cycles} = '0;
		{avs_read, avs_write, enter, leave, agp3, mode} = '0;
		{avs_addr, avs_wdata, avs_be, en} = {8'h00, 32'h0, 4'hF, 12'hFFF};
		{c0, c1, c2, hi} = {57'h1, 32'h3, 40'h1, {9{8'h01}}};
		{ext, hot, hit_modified_n, bsel, lock} = 5'h15;
		rst_in = 1'b1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		t_regs();
		t_entry();
		t_walk();
		t_modes();
		t_enable();
		t_agp3();
		t_exit();
		finish_test();
	end
endmodule : xor_chain_board_test_tb_top

`default_nettype wire
